// ==== src/pbc_bypass.sv ====
// port bypass control channels on port three pins
// Overview of operation
// - channels at 21h, 22h, 23h on pairs
// - channel at 20h drives pins one/zero
// - enable makes odd output, even input
// - enable overrides pins except bypass select
// - direction settings overridden while channel enabled
// - disabled channel bits leave pins alone
// - irq enable: any detect edge asserts interrupt
// - interrupt loads source with channel address
// - irq enable clear: edges raise nothing
// - force bit drives odd pin push-pull
// - force one high normal, zero low bypass
// - filtered detect low clears force within 400ns
// - detect bit read-only, follows even pin
// - detect one means signal present
// - reads return synchronized filtered pin values
// - pins come up as inputs after reset
// - force writes take effect only with detect high or the channel disabled
`timescale 1ns/1ps
module pbc_bypass #(
	parameter int FILTER_CYC = pbc_pkg::PBC_FILTER_CYC
) (
	input  wire logic                                 sys_clk,
	input  wire logic                                 rst,
	input  wire pbc_pkg::pbc_req_t                    req,
	output      pbc_pkg::pbc_rsp_t                    rsp,
	input  wire logic [pbc_pkg::PBC_NUM_PINS-1:0]     pin_in,
	output      logic [pbc_pkg::PBC_NUM_PINS-1:0]     pin_out,
	output      logic [pbc_pkg::PBC_NUM_PINS-1:0]     pin_oe_n,
	input  wire logic [pbc_pkg::PBC_NUM_PINS-1:0]     gpio_dir,
	input  wire logic [pbc_pkg::PBC_NUM_PINS-1:0]     gpio_data,
	input  wire logic [pbc_pkg::PBC_NUM_PINS-1:0]     bypass_sel,
	input  wire logic [pbc_pkg::PBC_NUM_PINS-1:0]     bypass_sel_data,
	input  wire logic                                 irq_ack,
	output      logic [7:0]                           source_addr,
	output      logic                                 irq_n
);
	import pbc_pkg::*;

	// loss of signal to a low force pin, in clocks: two
	// synchroniser stages, FILTER_CYC filter cycles, one to
	// clear the force bit and one to launch the pin; seven with
	// the default filter, well inside PBC_MAX_LAT_CYC, so raise
	// FILTER_CYC only with that budget in mind
	// channel and pin counts come from the package
	localparam int NC = PBC_NUM_CH;
	localparam int NP = PBC_NUM_PINS;
	localparam logic [PBC_FILT_CNT_W-1:0] FILT_LAST =
		PBC_FILT_CNT_W'(FILTER_CYC - 1);

	// channel address for index i
	function automatic logic [7:0] ch_addr(input int i);
		ch_addr = PBC_CH0_ADDR + 8'(i);
	endfunction

	// true when addr selects channel i
	// full byte compare, so no alias above the last channel
	function automatic logic ch_sel(input logic [7:0] a, input int i);
		ch_sel = (a == ch_addr(i));
	endfunction

	// pin side: synchroniser and filter state
	logic [NP-1:0]             sync1_q;
	logic [NP-1:0]             sync2_q;
	logic [NP-1:0]             filt_q;
	logic [PBC_FILT_CNT_W-1:0] cnt_q [NP];
	// per-channel control bits and events
	logic [NC-1:0]             en_q;
	logic [NC-1:0]             ie_q;
	logic [NC-1:0]             fb_q;
	logic [NC-1:0]             sd_prev_q;
	logic [NC-1:0]             edge_ev;
	logic [NC-1:0]             ch_wr;
	// interrupt, read port and pin drive state
	logic                      irq_pend_q;
	logic [7:0]                source_q;
	logic [7:0]                src_d;
	logic [7:0]                rd_val;
	logic                      rd_hit;
	pbc_rsp_t                  rsp_q;
	logic [NP-1:0]             out_q;
	logic [NP-1:0]             oe_n_q;

	// two-stage synchronizer; only sync2 is read downstream
	// resets to the pull-up level so no false edge follows
	// input synchronizer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= {NP{PBC_PIN_RST}};
			sync2_q <= {NP{PBC_PIN_RST}};
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// glitch filter: level must hold FILTER_CYC cycles to pass
	// shorter pulses never reach the channel logic, which keeps
	// a noisy detect line from toggling bypass
	// the count restarts whenever the input agrees again
	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_filt
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					filt_q[gp] <= PBC_PIN_RST;
					cnt_q[gp]  <= '0;
				end else if (sync2_q[gp] == filt_q[gp]) begin
					cnt_q[gp] <= '0;
				end else if (cnt_q[gp] >= FILT_LAST) begin
					filt_q[gp] <= sync2_q[gp];
					cnt_q[gp]  <= '0;
				end else begin
					cnt_q[gp] <= cnt_q[gp] + PBC_FILT_CNT_W'(1);
				end
			end
		end
	endgenerate

	genvar gc;
	generate
		for (gc = 0; gc < NC; gc++) begin : g_ch
			// one slice per channel: decode, bits, events, pins
			// the write strobe is qualified once here
			// per-channel address decode
			assign ch_wr[gc] = req.wr && ch_sel(req.addr, gc);

			// enable and irq enable bits, plain read/write
			// writes to a disabled channel still land; they act
			// once the enable bit is set
			// reset clears enables
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					en_q[gc] <= PBC_ENABLE_RST;
					ie_q[gc] <= PBC_IRQ_EN_RST;
				end else if (ch_wr[gc]) begin
					en_q[gc] <= req.wdata[PBC_ENABLE_BIT];
					ie_q[gc] <= req.wdata[PBC_IRQ_EN_BIT];
				end
			end

			// force bit: loss of signal beats any software write
			// the clear acts only while enabled, so a preset made
			// before the enable is cleared once enabled while the detect pin is still low
			// hardware clear of force
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					fb_q[gc] <= PBC_FORCE_RST;
				end else if (en_q[gc] && !filt_q[2*gc]) begin
					fb_q[gc] <= 1'b0;
				end else if (ch_wr[gc]) begin
					fb_q[gc] <= req.wdata[PBC_FORCE_BIT];
				end
			end

			// previous filtered detect level for edge finding
			// tracks while disabled too, so an enable never meets
			// a stale level and fakes an edge
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					sd_prev_q[gc] <= PBC_PIN_RST;
				end else begin
					sd_prev_q[gc] <= filt_q[2*gc];
				end
			end

			assign edge_ev[gc] = en_q[gc] && ie_q[gc]
				&& (filt_q[2*gc] != sd_prev_q[gc]);

			// odd pin of the pair: the force output
			// priority is bypass select, then channel, then gpio;
			// the select path must survive a channel enable
			// override except bypass select
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					out_q[2*gc+1]  <= 1'b0;
					oe_n_q[2*gc+1] <= 1'b1;
				end else if (bypass_sel[2*gc+1]) begin
					out_q[2*gc+1]  <= bypass_sel_data[2*gc+1];
					oe_n_q[2*gc+1] <= 1'b0;
				end else if (en_q[gc]) begin
					out_q[2*gc+1]  <= fb_q[gc];
					oe_n_q[2*gc+1] <= 1'b0; // totem pole, both levels
				end else begin
					out_q[2*gc+1]  <= gpio_data[2*gc+1];
					oe_n_q[2*gc+1] <= gpio_dir[2*gc+1];
				end
			end

			// even pin of the pair: the detect input
			// an enabled channel lets go of it so the far side
			// detect unit is fought only when bypass select drives the pin
			// odd output, even input
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					out_q[2*gc]  <= 1'b0;
					oe_n_q[2*gc] <= 1'b1;
				end else if (bypass_sel[2*gc]) begin
					out_q[2*gc]  <= bypass_sel_data[2*gc];
					oe_n_q[2*gc] <= 1'b0;
				end else if (en_q[gc]) begin
					out_q[2*gc]  <= 1'b0;
					oe_n_q[2*gc] <= 1'b1;
				end else begin
					out_q[2*gc]  <= gpio_data[2*gc];
					oe_n_q[2*gc] <= gpio_dir[2*gc];
				end
			end
		end
	endgenerate

	// lowest channel wins if several edges share a cycle
	// scanning downwards lets channel zero write last
	// source gets channel address
	always_comb begin
		src_d = source_q;
		for (int i = NC - 1; i >= 0; i--) begin
			if (edge_ev[i]) begin
				src_d = ch_addr(i);
			end
		end
	end

	// source holds the last reporting channel until the next edge;
	// an ack leaves it, so a late read still finds the cause
	// source register load
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			source_q <= PBC_SOURCE_RST;
		end else begin
			source_q <= src_d;
		end
	end

	// sticky pending flag; a new edge beats an ack in the same
	// cycle, so an event landing on the ack is never lost
	// interrupt assertion
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_pend_q <= 1'b0;
		end else if (|edge_ev) begin
			irq_pend_q <= 1'b1;
		end else if (irq_ack) begin
			irq_pend_q <= 1'b0;
		end
	end

	// read mux; reserved field is constant zero
	// unmapped reads fall through with hit low and data zero
	// a disabled channel's force bit reads the odd pin, so
	// software can learn a strapped default before enabling
	// detect follows even pin
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b0;
		for (int i = 0; i < NC; i++) begin
			if (ch_sel(req.addr, i)) begin
				rd_hit                 = 1'b1;
				rd_val[PBC_ENABLE_BIT] = en_q[i];
				rd_val[PBC_IRQ_EN_BIT] = ie_q[i];
				// disabled: force reads the pin itself
				rd_val[PBC_FORCE_BIT]  = en_q[i] ? fb_q[i] : filt_q[2*i+1];
				rd_val[PBC_DETECT_BIT] = filt_q[2*i];
			end
		end
	end

	// registered read answer, one cycle after the strobe
	// rdata is zero between answers, so a stale byte is never
	// mistaken for a fresh one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rsp_q <= '0;
		end else begin
			rsp_q.ack   <= req.rd;
			rsp_q.hit   <= req.rd && rd_hit;
			rsp_q.rdata <= req.rd ? rd_val : 8'h00;
		end
	end

	// every output comes straight from a flip-flop, irq_n through one inverter
	assign rsp         = rsp_q;
	assign pin_out     = out_q;
	assign pin_oe_n    = oe_n_q;
	assign source_addr = source_q;
	assign irq_n       = ~irq_pend_q; // active low interrupt line
endmodule

// ==== src/pbc_pkg.sv ====
// shared constants and types for the port bypass control channels
package pbc_pkg;
	// register map, byte addresses on the internal register port
	localparam logic [7:0] PBC_CH0_ADDR     = 8'h20; // bypass_channel_zero_control
	localparam logic [7:0] PBC_CH1_ADDR     = 8'h21; // bypass_channel_one_control
	localparam logic [7:0] PBC_CH2_ADDR     = 8'h22; // bypass_channel_two_control
	localparam logic [7:0] PBC_CH3_ADDR     = 8'h23; // bypass_channel_three_control
	localparam int         PBC_NUM_CH       = 4;
	localparam int         PBC_NUM_PINS     = 2 * PBC_NUM_CH;

	// field positions inside a channel control register
	localparam int         PBC_ENABLE_BIT   = 7; // bypass_channel_enable
	localparam int         PBC_IRQ_EN_BIT   = 6; // detect_transition_irq_enable
	localparam int         PBC_FORCE_BIT    = 1; // force_bypass_bit
	localparam int         PBC_DETECT_BIT   = 0; // signal_detect_bit

	// reset values
	localparam logic       PBC_ENABLE_RST   = 1'b0;
	localparam logic       PBC_IRQ_EN_RST   = 1'b0;
	localparam logic       PBC_FORCE_RST    = 1'b1;
	localparam logic       PBC_PIN_RST      = 1'b1; // weak pull-up level
	localparam logic [7:0] PBC_SOURCE_RST   = 8'h00;

	// timing: clock rate and longest loss-to-bypass latency
	localparam int         PBC_CLK_MHZ      = 50;
	localparam int         PBC_MAX_LAT_NS   = 400;
	localparam int         PBC_MAX_LAT_CYC  = (PBC_MAX_LAT_NS * PBC_CLK_MHZ)
		/ 1000;
	localparam int         PBC_FILTER_CYC   = 3;
	localparam int         PBC_FILT_CNT_W   = 4;

	// one register request from the host interface logic
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pbc_req_t;

	// read answer, valid for one cycle
	typedef struct packed {
		logic       ack;
		logic       hit;
		logic [7:0] rdata;
	} pbc_rsp_t;
endpackage

// ==== bench/pbc_far_model.sv ====
// far-side detect unit and pin wiring for port three
`timescale 1ns/1ps
module pbc_far_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [3:0] sig_ok,
	input  wire logic [3:0] pull_dn,
	output      logic [7:0] pin_in
);
	// device drive wins; odd pins float to the weak pull-up
	// unless a strap pulls them down to preset bypass
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = !pin_oe_n[i] ? pin_out[i]
				: (i[0] ? !pull_dn[i/2] : sig_ok[i/2]);
		end
	end
endmodule

// ==== bench/pbc_bypass_sva.sv ====
// port-level checks for the bypass channels
`timescale 1ns/1ps
module pbc_bypass_sva #(
	parameter int FILTER_CYC = 3
) (
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire pbc_pkg::pbc_req_t req,
	input wire pbc_pkg::pbc_rsp_t rsp,
	input wire logic [7:0]        pin_in,
	input wire logic [7:0]        pin_out,
	input wire logic [7:0]        pin_oe_n,
	input wire logic [7:0]        gpio_dir,
	input wire logic [7:0]        bypass_sel,
	input wire logic [7:0]        bypass_sel_data,
	input wire logic              irq_ack,
	input wire logic [7:0]        source_addr,
	input wire logic              irq_n
);
	import pbc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// register port, pin override and interrupt relations
	a_read_acked: assert property (
		req.rd |=> rsp.ack) else $error("read not answered");
	a_unmapped_zero: assert property (
		req.rd && req.addr[7:2] != 6'h08 |=> rsp.ack && !rsp.hit
		&& rsp.rdata == 8'h00) else $error("bad unmapped read");
	a_mapped_hit: assert property (
		req.rd && req.addr[7:2] == 6'h08 |=> rsp.ack && rsp.hit)
		else $error("mapped read missed");
	a_reserved_zero: assert property (
		rsp.ack |-> rsp.rdata[5:2] == 4'h0) else $error("reserved set");
	a_sel_drives: assert property (
		1'b1 |=> (pin_oe_n & $past(bypass_sel)) == 8'h00)
		else $error("select pin not driven");
	a_sel_data: assert property (
		1'b1 |=> ((pin_out ^ $past(bypass_sel_data))
		& $past(bypass_sel)) == 8'h00) else $error("select data");
	a_irq_holds: assert property (
		!irq_n && !irq_ack |=> !irq_n) else $error("irq dropped");
	a_source_chan: assert property (
		$fell(irq_n) |-> source_addr[7:2] == 6'h08)
		else $error("bad source");
	// long loss on the detect pin must leave bypass forced
	a_loss_bypass: assert property (
		(gpio_dir[1] && !bypass_sel[1] && !pin_oe_n[1] && !pin_in[0])[*8]
		|=> !pin_out[1]) else $error("force not cleared");
endmodule
bind pbc_bypass pbc_bypass_sva #(.FILTER_CYC(FILTER_CYC)) i_sva (
	.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
	.gpio_dir(gpio_dir), .bypass_sel(bypass_sel),
	.bypass_sel_data(bypass_sel_data), .irq_ack(irq_ack),
	.source_addr(source_addr), .irq_n(irq_n));

// ==== bench/pbc_bypass_tb.sv ====
// self-checking bench for the bypass channels
`timescale 1ns/1ps
module pbc_bypass_tb;
	import pbc_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	pbc_req_t   req = '0;
	pbc_rsp_t   rsp;
	logic [7:0] pin_in, pin_out, pin_oe_n, source_addr, a;
	logic [7:0] gpio_dir = 8'hff, gpio_data = 8'h00;
	logic [7:0] bypass_sel = 8'h00, bypass_sel_data = 8'h00;
	logic       irq_ack = 1'b0;
	logic       irq_n;
	logic [3:0] sig_ok = 4'hf;
	logic [3:0] pull_dn = 4'h0;
	logic [8:0] obs;
	int         fails = 0;
	int         n_tests = 0;

	always #10 sys_clk = ~sys_clk;
	assign obs = {irq_n, pin_out};

	pbc_bypass i_dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.gpio_dir(gpio_dir), .gpio_data(gpio_data), .bypass_sel(bypass_sel),
		.bypass_sel_data(bypass_sel_data), .irq_ack(irq_ack),
		.source_addr(source_addr), .irq_n(irq_n));
	pbc_far_model i_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.sig_ok(sig_ok), .pull_dn(pull_dn), .pin_in(pin_in));

	task automatic close_out;
		$display("checks %0d errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one access; reads compare d with the answer mid-cycle
	task automatic acc(input logic w, input logic [7:0] ad, d);
		@(posedge sys_clk);
		req <= '{w, !w, ad, d};
		@(posedge sys_clk);
		req <= '0;
		@(negedge sys_clk);
		if (!w)
			chk(rsp.rdata, d);
		@(negedge sys_clk);
	endtask

	// bounded wait, 400 ns at most; index 8 is the interrupt
	task automatic wait_for(input int p, input logic v);
		for (int k = 0; k < 20 && obs[p] !== v; k++)
			@(negedge sys_clk);
		chk({7'h00, obs[p]}, {7'h00, v});
		if (obs[p] !== v)
			close_out();
	endtask

	task automatic ack_irq;
		@(posedge sys_clk);
		irq_ack <= 1'b1;
		@(posedge sys_clk);
		irq_ack <= 1'b0;
		wait_for(8, 1'b1);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(negedge sys_clk);
		chk(pin_oe_n, 8'hff);
		acc(1'b0, 8'h24, 8'h00);
		for (int c = 0; c < 4; c++) begin
			a = PBC_CH0_ADDR + 8'(c);
			acc(1'b0, a, 8'h03);
			acc(1'b1, a, 8'hfe);
			acc(1'b0, a, 8'hc3);
			chk({pin_out[2*c+1], 5'h00, pin_oe_n[2*c+:2]}, 8'h81);
			@(posedge sys_clk);
			sig_ok[c] <= 1'b0;
			wait_for(2*c+1, 1'b0);
			wait_for(8, 1'b0);
			chk(source_addr, a);
			acc(1'b1, a, 8'hc2);
			acc(1'b0, a, 8'hc0);
			ack_irq();
			@(posedge sys_clk);
			sig_ok[c] <= 1'b1;
			wait_for(8, 1'b0);
			ack_irq();
			acc(1'b1, a, 8'hc2);
			wait_for(2*c+1, 1'b1);
		end
		acc(1'b1, PBC_CH0_ADDR, 8'h82);
		@(posedge sys_clk);
		sig_ok[0] <= 1'b0;
		repeat (20) @(negedge sys_clk);
		chk({7'h00, irq_n}, 8'h01);
		@(posedge sys_clk);
		bypass_sel <= 8'h02;
		bypass_sel_data <= 8'h02;
		wait_for(1, 1'b1);
		acc(1'b1, PBC_CH2_ADDR, 8'h02);
		@(posedge sys_clk);
		gpio_dir <= 8'h00;
		gpio_data <= 8'h10;
		repeat (3) @(negedge sys_clk);
		chk({pin_out[7], pin_out[5:4], 1'b0, pin_oe_n[7:4]}, 8'ha4);
		// mid-run reset with the channel three force pin strapped low
		@(posedge sys_clk);
		rst <= 1'b1;
		bypass_sel <= 8'h00;
		gpio_dir <= 8'hff;
		pull_dn <= 4'h8;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(negedge sys_clk);
		chk(pin_oe_n, 8'hff);
		chk({source_addr[7:1], irq_n}, 8'h01);
		acc(1'b0, PBC_CH3_ADDR, 8'h01);
		acc(1'b1, PBC_CH3_ADDR, 8'h00);
		acc(1'b1, PBC_CH3_ADDR, 8'h80);
		chk({5'h00, pin_out[7], pin_oe_n[7:6]}, 8'h01);
		acc(1'b0, PBC_CH3_ADDR, 8'h81);
		close_out();
	end
endmodule
